// ==== rtl/auxres_bank.sv ====
// Purpose: read-only result registers of the auxiliary channels
// Assumes: engine and register port run on ref_clk, no synchronisers
// Notes:   one-cycle read latency, slave never stalls
//          a status word reports the full scale behind each stored code
`include "auxres_regs.svh"

module auxres_bank (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  // register port
  input  wire logic [`AUXRES_AW-1:0]      addr,
  input  wire logic [`AUXRES_DW-1:0]      wr_data,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [`AUXRES_DW-1:0]      rd_data,
  // acquisition engine
  input  wire auxres_pkg::auxres_scan_t   scan,
  output logic                            aux_ref_absolute,
  output logic      [`AUXRES_NCH-1:0]     aux_measure_enable,
  output logic      [`AUXRES_NCH-1:0]     aux_analog_input_mode
);

  // ****************************************
  // state
  // ****************************************
  auxres_pkg::auxres_ctrl_t ctrl;
  logic [`AUXRES_CW-1:0]    res [`AUXRES_NCH];
  logic                     tag [`AUXRES_NCH];
  logic [`AUXRES_DW-1:0]    next_rd_data;
  logic [`AUXRES_NCH-1:0]   upd;

  // ****************************************
  // control register
  // ****************************************

  // software steers enable, analog mode and reference choice
  // only the control address is writable; results have no write port
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      ctrl <= `AUXRES_CTRL_RST;
    else if (wr_en && addr == `AUXRES_OFS_CTRL)
      ctrl <= auxres_pkg::auxres_ctrl_t'(wr_data[$bits(ctrl)-1:0]);
  end

  // control fields go straight to the engine
  assign aux_ref_absolute      = ctrl.ref_abs;
  assign aux_measure_enable    = ctrl.en;
  assign aux_analog_input_mode = ctrl.mode;

  // ****************************************
  // result channels
  // ****************************************
  for (genvar i = 0; i < `AUXRES_NCH; i++)
  begin : g_ch
    // only a measured, enabled, analog channel takes a new code
    assign upd[i] = scan.done && scan.measured[i] && ctrl.en[i] && ctrl.mode[i];

    // no write path at all: bus writes cannot reach the result
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
        res[i] <= `AUXRES_RST14;
      else if (upd[i])
        res[i] <= scan.code[i];
    end

    // codes kept as delivered; rescaling here would lose resolution
    // remember which full scale the stored code refers to
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
        tag[i] <= `AUXRES_RST1;
      else if (upd[i])
        tag[i] <= ctrl.ref_abs;
    end

    // ****************************************
    // per-channel checks
    // ****************************************

    // a disabled channel keeps its code through a scan
    skip_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      scan.done && !ctrl.en[i] |=> res[i] == $past(res[i]))
      else $error("skipped channel result changed");

    // a channel left out of the scan keeps its code too
    unmeasured_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      scan.done && !scan.measured[i] |=> res[i] == $past(res[i]))
      else $error("unmeasured channel result changed");

    // a port in another function never takes a code
    not_updated_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      scan.done && !ctrl.mode[i] |=> res[i] == $past(res[i]))
      else $error("non-analog channel result changed");

    // a qualifying scan stores the delivered code
    code_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      upd[i] |=> res[i] == $past(scan.code[i]))
      else $error("scan code not stored");

    // bus writes leave the result alone
    write_ignored_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_en && !upd[i] |=> res[i] == $past(res[i]))
      else $error("write altered a result register");

    // nothing but a qualifying scan moves the result
    res_quiet_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      !upd[i] |=> res[i] == $past(res[i]))
      else $error("result changed without a scan");

    // tag taken with the code, from the mode of that cycle
    ref_tag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      upd[i] ##1 !upd[i] [*2] |-> tag[i] == $past(ctrl.ref_abs, 2))
      else $error("reference tag does not follow mode");

    // tag only moves together with a new code
    tag_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      !upd[i] |=> tag[i] == $past(tag[i]))
      else $error("reference tag changed without a scan");

    // status bit i reports the full scale of the stored code
    status_bit_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      rd_en && addr == `AUXRES_OFS_STAT |=> rd_data[i] == $past(tag[i]))
      else $error("status bit does not match stored scale");

    // an analog channel reads its code over the pad bits
    read_value_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      rd_en && addr == `AUXRES_OFS_CH0 + 8'(i) && ctrl.mode[i]
      |=> rd_data == {$past(res[i]), `AUXRES_PAD})
      else $error("result read returned wrong value");

    // a non-analog channel reads zero whatever is stored
    not_analog_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      rd_en && addr == `AUXRES_OFS_CH0 + 8'(i) && !ctrl.mode[i]
      |=> rd_data == `AUXRES_RST16)
      else $error("non-analog channel read not zero");
  end

  // ****************************************
  // read path
  // ****************************************

  // mode gates the read, not only the store, so a port switched back
  // to analog shows its last code again; a status read tells, per
  // channel, which full scale that stored code was taken against
  // address decode; unmapped addresses answer zero
  always_comb
  begin
    next_rd_data = `AUXRES_RST16;
    for (int k = 0; k < `AUXRES_NCH; k++)
    begin
      if (addr == `AUXRES_OFS_CH0 + 8'(k) && ctrl.mode[k])
        next_rd_data = {res[k], `AUXRES_PAD};
      // status bits sit at the channel numbers
      if (addr == `AUXRES_OFS_STAT)
        next_rd_data[k] = tag[k];
    end
    if (addr == `AUXRES_OFS_CTRL)
      next_rd_data = `AUXRES_DW'(ctrl);
  end

  // data stands only in the cycle after the strobe, zero elsewhere
  // clearing it keeps stale codes off a shared read bus
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rd_data <= `AUXRES_RST16;
    else if (rd_en)
      rd_data <= next_rd_data;
    else
      rd_data <= `AUXRES_RST16;
  end

  // ****************************************
  // bank-wide checks
  // ****************************************

  // the pad bits of every result word stay clear
  low_bits_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_en && addr >= `AUXRES_OFS_CH0 && addr <= `AUXRES_OFS_CH4
    |=> rd_data[1:0] == `AUXRES_PAD)
    else $error("unused low result bits not zero");

  // the reference choice follows the control write
  ctrl_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_en && addr == `AUXRES_OFS_CTRL
    |=> aux_ref_absolute == $past(wr_data[$bits(ctrl)-1]))
    else $error("reference mode not taken from write");

  // control reads back in its low bits, zeros above
  ctrl_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_en && addr == `AUXRES_OFS_CTRL
    |=> rd_data == `AUXRES_DW'($past(ctrl)))
    else $error("control readback wrong");

  // read data stands for one cycle only
  idle_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !rd_en |=> rd_data == `AUXRES_RST16)
    else $error("read data outside its cycle");

  // main scenarios: fresh code read at once, skipped channel, non-analog
  // read, back-to-back strobes, a status word with a scale bit set
  cov_update_c:  cover property (@(posedge ref_clk) disable iff (!resetn)
    scan.done && upd != '0 ##1 rd_en);
  cov_skip_c:    cover property (@(posedge ref_clk) disable iff (!resetn)
    scan.done && scan.measured != '0 && ctrl.en != ctrl.mode);
  cov_noanalog_c: cover property (@(posedge ref_clk) disable iff (!resetn)
    rd_en && addr == `AUXRES_OFS_CH2 && !ctrl.mode[2]);
  cov_b2b_c:     cover property (@(posedge ref_clk) disable iff (!resetn)
    wr_en ##1 rd_en ##1 rd_en);
  cov_status_c:  cover property (@(posedge ref_clk) disable iff (!resetn)
    rd_en && addr == `AUXRES_OFS_STAT ##1 rd_data != '0);

endmodule : auxres_bank

// ==== rtl/auxres_regs.svh ====
// Purpose: offsets, field positions and reset values of the aux result bank
// Assumes: byte-wide register address, 16-bit register data
// Notes:   result channels sit at consecutive addresses from channel 0
`ifndef AUXRES_REGS_SVH
`define AUXRES_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define AUXRES_OFS_CH0   8'h59
`define AUXRES_OFS_CH1   8'h5a
`define AUXRES_OFS_CH2   8'h5b
`define AUXRES_OFS_CH3   8'h5c
`define AUXRES_OFS_CH4   8'h5d
`define AUXRES_OFS_CTRL  8'h70
`define AUXRES_OFS_STAT  8'h71

// ****************************************
// widths, fields and reset values
// ****************************************
`define AUXRES_NCH       5
`define AUXRES_CW        14
`define AUXRES_AW        8
`define AUXRES_DW        16
`define AUXRES_PAD       2'b00
`define AUXRES_RST16     16'h0000
`define AUXRES_RST14     14'h0000
`define AUXRES_RST1      1'b0
`define AUXRES_CTRL_RST  11'h000

`endif

// ==== rtl/auxres_pkg.sv ====
// Purpose: shared types of the aux result bank
// Assumes: constants come from auxres_regs.svh
// Notes:   control struct order matches its register bit layout
`include "auxres_regs.svh"

package auxres_pkg;

  // one scan report from the acquisition engine
  typedef struct packed {
    logic                                  done;
    logic [`AUXRES_NCH-1:0]                measured;
    logic [`AUXRES_NCH-1:0][`AUXRES_CW-1:0] code;
  } auxres_scan_t;

  // control register: bit 10 ref, bits 9:5 analog mode, bits 4:0 enable
  typedef struct packed {
    logic                   ref_abs;
    logic [`AUXRES_NCH-1:0] mode;
    logic [`AUXRES_NCH-1:0] en;
  } auxres_ctrl_t;

endpackage : auxres_pkg

// ==== dv/aux_result_registers_bench.sv ====
// Purpose: self-checking bench of the aux result bank
// Assumes: ref_clk 40 MHz, bench drives by nba after the rising edge
// Notes:   one task per scenario; read data sampled one cycle after rd_en
`include "auxres_regs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL t=%0t got %h exp %h", $time, g, e); end end

module aux_result_registers_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     ref_clk = 1'b0;
  logic                     resetn = 1'b0;
  logic [`AUXRES_AW-1:0]    addr = 8'h00;
  logic [`AUXRES_DW-1:0]    wr_data = 16'h0000;
  logic                     wr_en = 1'b0;
  logic                     rd_en = 1'b0;
  logic [`AUXRES_DW-1:0]    rd_data;
  auxres_pkg::auxres_scan_t scan = '0;
  logic                     ref_abs;
  logic [`AUXRES_NCH-1:0]   en_o;
  logic [`AUXRES_NCH-1:0]   mode_o;
  logic [`AUXRES_CW-1:0]    code [`AUXRES_NCH];
  int                       miscompares = 0;
  int                       checked = 0;
  int                       cycles = 0;

  auxres_bank auxres_bank_i (.ref_clk(ref_clk), .resetn(resetn), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .scan(scan),
    .aux_ref_absolute(ref_abs), .aux_measure_enable(en_o), .aux_analog_input_mode(mode_o));

  // 25 ns period; hang guard far above the roughly 90 cycles needed
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // ****************************************
  // bus and scan drivers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
  endtask : wr

  // data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 `CHK(rd_data, e)
  endtask : rd_chk

  task automatic do_scan(input logic [4:0] meas);
    @(posedge ref_clk);
    for (int i = 0; i < 5; i++) scan.code[i] <= code[i];
    scan.measured <= meas;
    scan.done     <= 1'b1;
    @(posedge ref_clk);
    scan.done     <= 1'b0;
  endtask : do_scan

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    for (int i = 0; i < 5; i++) rd_chk(`AUXRES_OFS_CH0 + 8'(i), 16'h0000);
    `CHK({ref_abs, mode_o, en_o}, 11'h000)
  endtask : t_reset

  // full-scale code on ch0 exposes any leak into the low bits
  task automatic t_full();
    for (int i = 0; i < 5; i++) code[i] = 14'h3fff - 14'(i * 14'h0123);
    wr(`AUXRES_OFS_CTRL, {5'h00, 1'b1, 5'h1f, 5'h1f});
    #1 `CHK(ref_abs, 1'b1)
    do_scan(5'h1f);
    for (int i = 0; i < 5; i++)
    begin
      rd_chk(`AUXRES_OFS_CH0 + 8'(i), {code[i], 2'b00});
    end
  endtask : t_full

  task automatic t_write();
    wr(`AUXRES_OFS_CH1, 16'hffff);
    rd_chk(`AUXRES_OFS_CH1, {code[1], 2'b00});
    rd_chk(8'h00, 16'h0000);
  endtask : t_write

  task automatic t_skip();
    logic [15:0] old2;
    old2 = {code[2], 2'b00};
    for (int i = 0; i < 5; i++) code[i] = 14'h0a5a + 14'(i);
    wr(`AUXRES_OFS_CTRL, {5'h00, 1'b0, 5'h17, 5'h1b});
    #1 `CHK(ref_abs, 1'b0)
    do_scan(5'h1e);
    rd_chk(`AUXRES_OFS_CH2, old2);
    rd_chk(`AUXRES_OFS_CH1, {code[1], 2'b00});
    rd_chk(`AUXRES_OFS_CH0, 16'hfffc);
    rd_chk(`AUXRES_OFS_CH3, 16'h0000);
  endtask : t_skip

  task automatic t_mode();
    wr(`AUXRES_OFS_CTRL, {5'h00, 1'b0, 5'h17, 5'h1f});
    #1 `CHK({mode_o, en_o}, 10'h2ff)
    rd_chk(`AUXRES_OFS_CH3, 16'h0000);
    rd_chk(`AUXRES_OFS_CH4, {code[4], 2'b00});
  endtask : t_mode

  // gapless write, scan and reads; each word checked in its only cycle
  task automatic t_burst();
    for (int i = 0; i < 5; i++) code[i] = 14'h2000 + 14'(i);
    @(posedge ref_clk);
    addr    <= `AUXRES_OFS_CTRL;
    wr_data <= 16'h07ff;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
    rd_en   <= 1'b1;
    for (int i = 0; i < 5; i++) scan.code[i] <= code[i];
    scan.measured <= 5'h1f;
    scan.done     <= 1'b1;
    @(posedge ref_clk);
    scan.done <= 1'b0;
    addr      <= `AUXRES_OFS_CH3;
    #1 `CHK(rd_data, 16'h07ff)
    @(posedge ref_clk);
    addr <= `AUXRES_OFS_STAT;
    #1 `CHK(rd_data, {code[3], 2'b00})
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 `CHK(rd_data, 16'h001f)
    @(posedge ref_clk);
    #1 `CHK(rd_data, 16'h0000)
  endtask : t_burst

  // a mid-run reset must clear codes, scale tags and control alike
  task automatic t_rereset();
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 `CHK({ref_abs, mode_o, en_o}, 11'h000)
    `CHK(rd_data, 16'h0000)
    @(posedge ref_clk);
    resetn <= 1'b1;
    wr(`AUXRES_OFS_CTRL, {5'h00, 1'b0, 5'h1f, 5'h00});
    for (int i = 0; i < 5; i++) rd_chk(`AUXRES_OFS_CH0 + 8'(i), 16'h0000);
    rd_chk(`AUXRES_OFS_STAT, 16'h0000);
  endtask : t_rereset

  initial
  begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_full();
    t_write();
    t_skip();
    t_mode();
    t_burst();
    t_rereset();
    report_and_stop();
  end
endmodule : aux_result_registers_bench
